// [rtl/psr_pkg.sv]
// Package of constants and carriers for the program status word logic.
package psr_pkg;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int NEG_BIT    = 31;
  localparam int ZERO_BIT   = 30;
  localparam int CARRY_BIT  = 29;
  localparam int OVF_BIT    = 28;
  localparam int SAT_BIT    = 27;
  localparam int ISET_BIT   = 24;
  localparam int GE_LSB     = 16;
  localparam int EXC_W      = 9;

  // ----------------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] APP_MASK   = 32'hF80F0000;
  localparam logic [31:0] EXC_MASK   = 32'h000001FF;
  localparam logic [31:0] EXEC_MASK  = 32'h0700FC00;
  localparam logic [31:0] WORD_RESET = 32'h01000000;
  localparam logic [8:0]  EXC_THREAD = 9'h000;
  localparam logic [8:0]  EXC_IRQ0   = 9'h010;
  localparam logic [8:0]  EXC_LAST   = 9'h053;
  localparam logic [3:0]  BLOCK_IDLE = 4'h0;

  // ----------------------------------------------------------------------
  // System exception numbers
  // ----------------------------------------------------------------------
  localparam logic [8:0] EXC_NMI    = 9'h002;
  localparam logic [8:0] EXC_HARD   = 9'h003;
  localparam logic [8:0] EXC_MEM    = 9'h004;
  localparam logic [8:0] EXC_BUS    = 9'h005;
  localparam logic [8:0] EXC_USAGE  = 9'h006;
  localparam logic [8:0] EXC_SVC    = 9'h00B;
  localparam logic [8:0] EXC_PEND   = 9'h00E;
  localparam logic [8:0] EXC_TICK   = 9'h00F;

  // Kind of state held in the shared execution bits.
  typedef enum logic [1:0] {
    PSR_EX_NONE   = 2'b00,
    PSR_EX_RESUME = 2'b01,
    PSR_EX_BLOCK  = 2'b10
  } psr_exec_kind_t;

  // Result flags from the execution unit.
  typedef struct packed {
    logic       neg;
    logic       zero;
    logic       carry;
    logic       ovf;
    logic       sat;
    logic [3:0] ge;
  } psr_flags_t;

  // Software status move request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        wr_flags;
    logic        wr_ge;
    logic [31:0] data;
  } psr_move_t;

endpackage : psr_pkg

// [rtl/psr_status.sv]
// Program status word: condition, exception and execution views.
`timescale 1ns/100ps
`default_nettype none
module psr_status #(
  parameter int IRQ_LINES = 82
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Flag updates from the execution unit
  input  wire logic                  flags_we,
  input  wire logic                  ge_we,
  input  wire psr_pkg::psr_flags_t   flags_in,
  // Status move instructions
  input  wire psr_pkg::psr_move_t    move,
  // Exception sequencing
  input  wire logic                  exc_enter,
  input  wire logic [8:0]            exc_number,
  input  wire logic                  exc_return,
  input  wire logic [31:0]           stacked_word,
  input  wire logic                  vector_load,
  input  wire logic [31:0]           vector_value,
  input  wire logic                  branch_exchange,
  input  wire logic [31:0]           branch_target,
  // Multi transfer and conditional block control
  input  wire logic                  multi_suspend,
  input  wire logic [3:0]            multi_next_index,
  input  wire logic                  block_start,
  input  wire logic [7:0]            block_code,
  input  wire logic                  block_step,
  input  wire logic                  instr_issue,
  // Outputs
  output logic [31:0]                combined_status_word,
  output logic [31:0]                move_read_data,
  output logic [31:0]                stacked_status_word,
  output logic [3:0]                 multi_resume_index,
  output logic                       block_active,
  output logic                       block_invert,
  output logic                       state_fault
);

  // ----------------------------------------------------------------------
  // Held state
  // ----------------------------------------------------------------------
  logic                    neg, zero, carry, ovf, sat;
  logic [3:0]              ge;
  logic [8:0]              active_exception_number;
  logic                    iset;
  logic [7:0]              exec_bits;
  psr_pkg::psr_exec_kind_t exec_kind;
  logic [31:0]             next_word;
  logic [31:0]             next_readable;
  logic                    exc_legal;

  // The 8 shared bits map to 26:25 and 15:10 of the word.
  always_comb begin
    next_word = '0;
    next_word[psr_pkg::NEG_BIT]   = neg;
    next_word[psr_pkg::ZERO_BIT]  = zero;
    next_word[psr_pkg::CARRY_BIT] = carry;
    next_word[psr_pkg::OVF_BIT]   = ovf;
    next_word[psr_pkg::SAT_BIT]   = sat;
    next_word[19:16]              = ge;
    next_word[8:0]                = active_exception_number;
    next_word[psr_pkg::ISET_BIT]  = iset;
    next_word[26:25]              = exec_bits[7:6];
    next_word[15:10]              = exec_bits[5:0];
  end

  assign next_readable = next_word & ~psr_pkg::EXEC_MASK;
  // last external number; a smaller line count cuts the range further.
  assign exc_legal     = (exc_number <= psr_pkg::EXC_LAST) &&
                         (exc_number < psr_pkg::EXC_IRQ0 + 9'(IRQ_LINES));

  // ----------------------------------------------------------------------
  // Condition flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      neg   <= 1'b0;
      zero  <= 1'b0;
      carry <= 1'b0;
      ovf   <= 1'b0;
    end else if (exc_return) begin
      {neg, zero, carry, ovf} <= stacked_word[31:28];
    end else if (flags_we) begin
      neg   <= flags_in.neg;
      zero  <= flags_in.zero;
      carry <= flags_in.carry;
      ovf   <= flags_in.ovf;
    end else if (move.wr && move.wr_flags) begin
      {neg, zero, carry, ovf} <= move.data[31:28];
    end
  end

  // Saturation is sticky; a new saturation wins over a software clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      sat <= 1'b0;
    end else if (exc_return) begin
      sat <= stacked_word[psr_pkg::SAT_BIT];
    end else if (flags_we && flags_in.sat) begin
      sat <= 1'b1;
    end else if (move.wr && move.wr_flags) begin
      sat <= move.data[psr_pkg::SAT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ge <= '0;
    end else if (exc_return) begin
      ge <= stacked_word[19:16];
    end else if (ge_we) begin
      ge <= flags_in.ge;
    end else if (move.wr && move.wr_ge) begin
      ge <= move.data[19:16];
    end
  end

  // ----------------------------------------------------------------------
  // Exception number
  // ----------------------------------------------------------------------
  // software writes never reach this register.
  always_ff @(posedge clk) begin
    if (reset) begin
      active_exception_number <= psr_pkg::EXC_THREAD;
    end else if (exc_enter && exc_legal) begin
      active_exception_number <= exc_number;
    end else if (exc_return) begin
      active_exception_number <= stacked_word[8:0];
    end
  end

  // ----------------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      iset <= 1'b1;
    end else if (vector_load) begin
      iset <= vector_value[0];
    end else if (exc_return) begin
      iset <= stacked_word[psr_pkg::ISET_BIT];
    end else if (branch_exchange) begin
      iset <= branch_target[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      exec_bits <= '0;
      exec_kind <= psr_pkg::PSR_EX_NONE;
    end else if (exc_return) begin
      exec_bits <= {stacked_word[26:25], stacked_word[15:10]};
      exec_kind <= (stacked_word[15:12] != psr_pkg::BLOCK_IDLE &&
                    stacked_word[26:25] == 2'b00 && stacked_word[11:10] == 2'b00)
                   ? psr_pkg::PSR_EX_RESUME : psr_pkg::PSR_EX_NONE;
    end else if (multi_suspend) begin
      exec_bits <= {2'b00, multi_next_index, 2'b00};
      exec_kind <= psr_pkg::PSR_EX_RESUME;
    end else if (block_start) begin
      exec_bits <= block_code;
      exec_kind <= psr_pkg::PSR_EX_BLOCK;
    end else if (block_step && exec_kind == psr_pkg::PSR_EX_BLOCK) begin
      // A stray step would otherwise shift a held resume index.
      // advance mask, at most four
      if (exec_bits[3:0] == 4'h8 || exec_bits[3:0] == 4'h0) begin
        exec_bits <= '0;
        exec_kind <= psr_pkg::PSR_EX_NONE;
      end else begin
        exec_bits <= {exec_bits[7:5], exec_bits[4:0] << 1};
      end
    end else if (exec_kind == psr_pkg::PSR_EX_RESUME && instr_issue) begin
      exec_bits <= '0;
      exec_kind <= psr_pkg::PSR_EX_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      combined_status_word <= psr_pkg::WORD_RESET;
      move_read_data       <= '0;
      stacked_status_word  <= psr_pkg::WORD_RESET;
      multi_resume_index   <= '0;
      block_active         <= 1'b0;
      block_invert         <= 1'b0;
      state_fault          <= 1'b0;
    end else begin
      combined_status_word <= next_word;
      if (move.rd) begin
        move_read_data <= next_readable;
      end
      stacked_status_word <= next_word;
      multi_resume_index  <= (exec_kind == psr_pkg::PSR_EX_RESUME) ? exec_bits[5:2] : 4'h0;
      block_active        <= (exec_kind == psr_pkg::PSR_EX_BLOCK);
      block_invert        <= (exec_kind == psr_pkg::PSR_EX_BLOCK) &&
                             (exec_bits[4] != exec_bits[2]);
      state_fault         <= instr_issue && !iset;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence sat_event_s;
    flags_we && flags_in.sat;
  endsequence

  sat_sticky_a: assert property (@(posedge clk) disable iff (reset)
    sat_event_s |=> sat) else $error("saturation flag not set");
  sat_hold_a: assert property (@(posedge clk) disable iff (reset)
    sat && !(move.wr && move.wr_flags) && !exc_return |=> sat)
    else $error("saturation flag cleared by itself");
  zero_flag_a: assert property (@(posedge clk) disable iff (reset)
    flags_we && !exc_return |=> ##1
    combined_status_word[psr_pkg::ZERO_BIT] == $past(flags_in.zero, 2))
    else $error("zero flag wrong");
  neg_flag_a: assert property (@(posedge clk) disable iff (reset)
    flags_we && !exc_return |=> neg == $past(flags_in.neg)) else $error("neg flag wrong");
  exec_hidden_a: assert property (@(posedge clk) disable iff (reset)
    (move_read_data & psr_pkg::EXEC_MASK) == 32'h00000000) else $error("exec bits readable");
  resume_zero_a: assert property (@(posedge clk) disable iff (reset)
    multi_suspend && !exc_return |=> ##1 combined_status_word[26:25] == 2'b00 &&
    combined_status_word[11:10] == 2'b00 && combined_status_word[15:12] == $past(multi_next_index, 2))
    else $error("resume state malformed");
  exc_keep_a: assert property (@(posedge clk) disable iff (reset)
    !exc_enter && !exc_return |=> $stable(active_exception_number))
    else $error("exception number changed");
  iset_fault_a: assert property (@(posedge clk) disable iff (reset)
    instr_issue && !iset |=> state_fault) else $error("missing state fault");

  // Status moves alone must leave the shared execution bits as they were.
  sequence exec_quiet_s;
    !exc_return && !multi_suspend && !block_start && !block_step && !instr_issue;
  endsequence

  sequence block_open_s;
    block_start && !exc_return && !multi_suspend;
  endsequence

  sequence suspend_s;
    multi_suspend && !exc_return;
  endsequence

  carry_flag_a: assert property (@(posedge clk) disable iff (reset)
    flags_we && !exc_return |=> carry == $past(flags_in.carry))
    else $error("carry flag wrong");
  ovf_flag_a: assert property (@(posedge clk) disable iff (reset)
    flags_we && !exc_return |=> ovf == $past(flags_in.ovf))
    else $error("overflow flag wrong");
  ge_load_a: assert property (@(posedge clk) disable iff (reset)
    ge_we && !exc_return |=> ge == $past(flags_in.ge))
    else $error("byte compare flags wrong");
  exc_load_a: assert property (@(posedge clk) disable iff (reset)
    exc_enter && exc_legal |=> active_exception_number == $past(exc_number))
    else $error("exception number not loaded");
  exc_range_a: assert property (@(posedge clk) disable iff (reset)
    exc_enter && !exc_return && exc_number > psr_pkg::EXC_LAST
    |=> $stable(active_exception_number))
    else $error("out of range exception number taken");
  word_reserved_a: assert property (@(posedge clk) disable iff (reset)
    (combined_status_word & ~(psr_pkg::APP_MASK | psr_pkg::EXC_MASK | psr_pkg::EXEC_MASK))
    == 32'h00000000) else $error("reserved bits not zero");
  iset_vector_a: assert property (@(posedge clk) disable iff (reset)
    vector_load |=> iset == $past(vector_value[0]))
    else $error("state bit not loaded from vector");
  iset_branch_a: assert property (@(posedge clk) disable iff (reset)
    branch_exchange && !vector_load && !exc_return |=> iset == $past(branch_target[0]))
    else $error("state bit not loaded from branch");
  move_exec_a: assert property (@(posedge clk) disable iff (reset)
    move.wr ##0 exec_quiet_s |=> $stable(exec_bits))
    else $error("status move changed exec bits");
  block_open_a: assert property (@(posedge clk) disable iff (reset)
    block_open_s |=> ##1 block_active)
    else $error("block state not shown");
  resume_index_a: assert property (@(posedge clk) disable iff (reset)
    suspend_s |=> ##1 multi_resume_index == $past(multi_next_index, 2))
    else $error("resume index not shown");
  resume_clear_a: assert property (@(posedge clk) disable iff (reset)
    exec_kind == psr_pkg::PSR_EX_RESUME && instr_issue && !exc_return && !multi_suspend &&
    !block_start && !block_step |=> exec_kind == psr_pkg::PSR_EX_NONE)
    else $error("resume state not consumed");

endmodule : psr_status
`default_nettype wire

// [sim/test_program_status_register.sv]
// Self-checking testbench for the program status word logic.
`timescale 1ns/100ps
`default_nettype none
module test_program_status_register;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int K_ENTER = 0;
  localparam int K_RET   = 1;
  localparam int K_VEC   = 2;
  localparam int K_BR    = 3;
  localparam int K_SUSP  = 4;
  localparam int K_BLOCK = 5;
  localparam int K_STEP  = 6;
  localparam int K_ISSUE = 7;

  logic                clk;
  logic                reset;
  logic                flags_we;
  logic                ge_we;
  psr_pkg::psr_flags_t flags_in;
  psr_pkg::psr_move_t  move;
  logic                exc_enter;
  logic [8:0]          exc_number;
  logic                exc_return;
  logic [31:0]         stacked_word;
  logic                vector_load;
  logic [31:0]         vector_value;
  logic                branch_exchange;
  logic [31:0]         branch_target;
  logic                multi_suspend;
  logic [3:0]          multi_next_index;
  logic                block_start;
  logic [7:0]          block_code;
  logic                block_step;
  logic                instr_issue;
  logic [31:0]         combined_status_word;
  logic [31:0]         move_read_data;
  logic [31:0]         stacked_status_word;
  logic [3:0]          multi_resume_index;
  logic                block_active;
  logic                block_invert;
  logic                state_fault;
  int                  fault_count = 0;
  int                  n_mismatch;
  int                  cmp_count;

  psr_status psr_status_inst (
    .clk                  (clk),
    .reset                (reset),
    .flags_we             (flags_we),
    .ge_we                (ge_we),
    .flags_in             (flags_in),
    .move                 (move),
    .exc_enter            (exc_enter),
    .exc_number           (exc_number),
    .exc_return           (exc_return),
    .stacked_word         (stacked_word),
    .vector_load          (vector_load),
    .vector_value         (vector_value),
    .branch_exchange      (branch_exchange),
    .branch_target        (branch_target),
    .multi_suspend        (multi_suspend),
    .multi_next_index     (multi_next_index),
    .block_start          (block_start),
    .block_code           (block_code),
    .block_step           (block_step),
    .instr_issue          (instr_issue),
    .combined_status_word (combined_status_word),
    .move_read_data       (move_read_data),
    .stacked_status_word  (stacked_status_word),
    .multi_resume_index   (multi_resume_index),
    .block_active         (block_active),
    .block_invert         (block_invert),
    .state_fault          (state_fault)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // The fault output is a one-cycle pulse, so it is counted here rather than polled.
  always @(posedge clk) if (state_fault === 1'b1) fault_count <= fault_count + 1;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Outputs stand until the next update, so a margin of three edges is safe.
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic put_flags(input psr_pkg::psr_flags_t f, input logic we, input logic gwe);
    @(posedge clk);
    flags_in <= f;
    flags_we <= we;
    ge_we    <= gwe;
    @(posedge clk);
    flags_we <= 1'b0;
    ge_we    <= 1'b0;
    settle();
  endtask : put_flags

  task automatic do_move(input logic rd, input logic wf, input logic wg, input logic [31:0] d);
    @(posedge clk);
    move <= '{rd: rd, wr: wf | wg, wr_flags: wf, wr_ge: wg, data: d};
    @(posedge clk);
    move <= '0;
    settle();
  endtask : do_move

  task automatic ctl(input int k, input logic [31:0] v);
    @(posedge clk);
    case (k)
      K_ENTER: begin exc_enter <= 1'b1; exc_number <= v[8:0]; end
      K_RET:   begin exc_return <= 1'b1; stacked_word <= v; end
      K_VEC:   begin vector_load <= 1'b1; vector_value <= v; end
      K_BR:    begin branch_exchange <= 1'b1; branch_target <= v; end
      K_SUSP:  begin multi_suspend <= 1'b1; multi_next_index <= v[3:0]; end
      K_BLOCK: begin block_start <= 1'b1; block_code <= v[7:0]; end
      K_STEP:  block_step <= 1'b1;
      default: instr_issue <= 1'b1;
    endcase
    @(posedge clk);
    {exc_enter, exc_return, vector_load, branch_exchange} <= 4'h0;
    {multi_suspend, block_start, block_step, instr_issue} <= 4'h0;
    settle();
  endtask : ctl

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_flags;
    logic [3:0] p;
    for (int i = 0; i < 5; i++) begin
      p = 4'h8 >> i;
      put_flags(psr_pkg::psr_flags_t'({p, 1'b0, 4'h0}), 1'b1, 1'b0);
      chk("nzcv", {28'h0, p}, {28'h0, combined_status_word[31:28]});
    end
  endtask : t_flags

  task automatic t_sticky;
    put_flags(psr_pkg::psr_flags_t'({4'h0, 1'b1, 4'h0}), 1'b1, 1'b0);
    chk("sat set", 32'h1, {31'h0, combined_status_word[27]});
    put_flags(psr_pkg::psr_flags_t'({4'h4, 1'b0, 4'h0}), 1'b1, 1'b0);
    chk("sat held", 32'h1, {31'h0, combined_status_word[27]});
    do_move(1'b0, 1'b1, 1'b0, 32'h00000000);
    chk("sat clear", 32'h0, {31'h0, combined_status_word[27]});
  endtask : t_sticky

  task automatic t_write;
    put_flags(psr_pkg::psr_flags_t'({4'h8, 1'b0, 4'hA}), 1'b0, 1'b1);
    chk("ge only", 32'h010A0000, combined_status_word);
    do_move(1'b0, 1'b1, 1'b1, 32'hFFFFFFFF);
    chk("write all", 32'hF90F0000, combined_status_word);
    do_move(1'b1, 1'b0, 1'b0, 32'h00000000);
    chk("read hide", 32'hF80F0000, move_read_data);
    do_move(1'b0, 1'b1, 1'b1, 32'h00000000);
    chk("write zero", 32'h01000000, combined_status_word);
  endtask : t_write

  task automatic t_exc;
    logic [8:0] nums [10] = '{9'h002, 9'h003, 9'h004, 9'h005, 9'h006,
                              9'h00B, 9'h00E, 9'h00F, 9'h010, 9'h053};
    foreach (nums[i]) begin
      ctl(K_ENTER, {23'h0, nums[i]});
      chk("exc number", {23'h0, nums[i]}, {23'h0, combined_status_word[8:0]});
    end
    ctl(K_ENTER, 32'h00000054);
    chk("exc range", 32'h00000053, {23'h0, combined_status_word[8:0]});
    ctl(K_RET, 32'h01000000);
    chk("thread", 32'h01000000, combined_status_word);
  endtask : t_exc

  task automatic t_resume;
    ctl(K_SUSP, 32'h00000005);
    chk("resume bits", 32'h01005000, combined_status_word & psr_pkg::EXEC_MASK);
    chk("resume idx", 32'h5, {28'h0, multi_resume_index});
    do_move(1'b1, 1'b0, 1'b0, 32'h00000000);
    chk("read resume", 32'h0, move_read_data & psr_pkg::EXEC_MASK);
    ctl(K_ENTER, 32'h00000010);
    chk("stacked", 32'h01005000, stacked_status_word & psr_pkg::EXEC_MASK);
    ctl(K_ISSUE, 32'h0);
    ctl(K_RET, 32'h01005000);
    chk("resumed", 32'h01005000, combined_status_word);
    chk("resume again", 32'h5, {28'h0, multi_resume_index});
    ctl(K_ISSUE, 32'h0);
  endtask : t_resume

  task automatic t_block;
    int n;
    ctl(K_BLOCK, 32'h00000008);
    chk("block on", 32'h1, {31'h0, block_active});
    chk("block bits", 32'h01002000, combined_status_word & psr_pkg::EXEC_MASK);
    chk("block inv", 32'h0, {31'h0, block_invert});
    for (int i = 0; i < 4 && block_active === 1'b1; i++) ctl(K_STEP, 32'h0);
    chk("block end", 32'h0, {31'h0, block_active});
    ctl(K_BLOCK, 32'h00000012);
    chk("block inv", 32'h1, {31'h0, block_invert});
    n = 0;
    for (int i = 0; i < 4 && block_active === 1'b1; i++) begin
      ctl(K_STEP, 32'h0);
      n++;
    end
    chk("block steps", 32'h3, n);
    chk("block end", 32'h0, {31'h0, block_active});
  endtask : t_block

  task automatic t_state;
    int f0;
    ctl(K_BR, 32'h00000000);
    chk("state clr", 32'h0, {31'h0, combined_status_word[24]});
    f0 = fault_count;
    ctl(K_ISSUE, 32'h0);
    chk("fault", 32'h1, fault_count - f0);
    ctl(K_VEC, 32'h00000001);
    chk("state vec", 32'h1, {31'h0, combined_status_word[24]});
    f0 = fault_count;
    ctl(K_ISSUE, 32'h0);
    chk("no fault", 32'h0, fault_count - f0);
    ctl(K_RET, 32'h00000000);
    chk("state ret", 32'h0, {31'h0, combined_status_word[24]});
    ctl(K_VEC, 32'h00000001);
  endtask : t_state

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    reset = 1'b1;
    {flags_we, ge_we, exc_enter, exc_return, vector_load, branch_exchange} = 6'h00;
    {multi_suspend, block_start, block_step, instr_issue} = 4'h0;
    flags_in = '0;
    move = '0;
    {exc_number, multi_next_index, block_code} = 21'h0;
    {stacked_word, vector_value, branch_target} = 96'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk("reset word", 32'h01000000, combined_status_word);
    chk("reset read", 32'h00000000, move_read_data);
    chk("reset stack", 32'h01000000, stacked_status_word);
    t_flags();
    t_sticky();
    t_write();
    t_exc();
    t_resume();
    t_block();
    t_state();
    test_done();
  end

  // The scenarios take well under a thousand cycles; this allows ample slack.
  initial begin
    #(40 * 20000);
    n_mismatch++;
    test_done();
  end

endmodule : test_program_status_register
`default_nettype wire
